// >>> shared/sfocr_defines.vh
// Purpose: constants for the fractional/output configuration register bank
// Assumes: 16-bit registers addressed by register number
// Notes:   definitions only
`ifndef SFOCR_DEFINES_VH
`define SFOCR_DEFINES_VH

// =====================================================================
// register numbers
`define SFOCR_ADDR_W          7
`define SFOCR_DATA_W          16
`define SFOCR_A_DEN_HI        7'h28
`define SFOCR_A_DEN_LO        7'h29
`define SFOCR_A_SEED_HI       7'h2a
`define SFOCR_A_SEED_LO       7'h2b
`define SFOCR_A_NUM_HI        7'h2c
`define SFOCR_A_NUM_LO        7'h2d
`define SFOCR_A_PWR_MOD       7'h2e
`define SFOCR_A_OUTA_SRC      7'h2f
`define SFOCR_A_OUTB_SRC      7'h30
`define SFOCR_A_MUX_DRV       7'h3b
`define SFOCR_A_LD_KIND       7'h3d

// =====================================================================
// reset values
`define SFOCR_RST_DEN         16'h03e8
`define SFOCR_RST_ZERO        16'h0000
`define SFOCR_RST_PWR_MOD     16'h0f80
`define SFOCR_RST_OUTA_SRC    16'h0000
`define SFOCR_RST_OUTB_SRC    16'h0000
`define SFOCR_RST_MUX_DRV     16'h0000
`define SFOCR_RST_LD_KIND     16'h0001

// =====================================================================
// field positions
`define SFOCR_F_ORDER         2:0
`define SFOCR_F_A_POW         13:8
`define SFOCR_F_B_PD          7
`define SFOCR_F_A_PD          6
`define SFOCR_F_A_SRC         12:11
`define SFOCR_F_B_POW         5:0
`define SFOCR_F_B_SRC         1:0
`define SFOCR_F_HDRV          5
`define SFOCR_F_LD_KIND       0

// =====================================================================
// encodings
`define SFOCR_ORDER_INT       3'h0
`define SFOCR_ORDER_MAX       3'h4
`define SFOCR_POW_NORM_MAX    6'h1f
`define SFOCR_POW_BOOST_MIN   6'h30
`define SFOCR_SRC_CHDIV       2'h0
`define SFOCR_SRC_OSC         2'h1
`define SFOCR_LD_CAL          1'b0

`endif

// >>> hw/sfocr_reg16.v
// Purpose: one 16-bit configuration register with word write
// Assumes: synchronous active-high reset
// Notes:   reset value is a parameter
`timescale 1ns/100ps
module sfocr_reg16 #(
  parameter [15:0] RST_VAL = 16'h0000
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        wr_i,
  input  wire [15:0] wdata_i,
  output wire [15:0] q_o
);
  reg [15:0] q_ff;
  always @(posedge clk_i) begin
    if (rst_i) begin
      q_ff <= RST_VAL;
    end else if (wr_i) begin
      q_ff <= wdata_i;
    end
  end
  assign q_o = q_ff;
endmodule

// >>> hw/sfocr_status_mux.v
// Purpose: selects what the multiplexed status pin reports
// Assumes: status inputs synchronous to clk_i
// Notes:   output registered
`timescale 1ns/100ps
`include "sfocr_defines.vh"
module sfocr_status_mux (
  input  wire clk_i,
  input  wire rst_i,
  input  wire lock_detect_kind_i,
  input  wire cal_done_i,
  input  wire vtune_locked_i,
  output wire mux_status_pin_o
);
  reg status_ff;
  always @(posedge clk_i) begin
    if (rst_i) begin
      status_ff <= 1'b0;
    end else if (lock_detect_kind_i == `SFOCR_LD_CAL) begin
      status_ff <= cal_done_i;     // [R11]
    end else begin
      status_ff <= vtune_locked_i; // [R12]
    end
  end
  assign mux_status_pin_o = status_ff;
endmodule

// >>> hw/sfocr_regs.v
// Contract
// R01: the fractional denominator is 32 bits, upper half then lower half, each reset to 1000.
// R02: the fractional numerator is 32 bits over two consecutive registers, both reset to 0.
// R03: modulator order in bits 2:0 picks fourth to first order, or integer mode at 0.
// R04: output A power in bits 13:8, 0..31 normal, 48..63 boost, reset 15.
// R05: output B power in bits 5:0 with the same coding, reset 0.
// R06: bit 7 powers down output B when 1, reset 1.
// R07: bit 6 powers down output A when 1, reset 0.
// R08: source selectors A bits 12:11 and B bits 1:0: 1 oscillator, 0 channel divider, 2-3 reserved.
// R09: bit 5 selects high drive on the status pin, reset 0.
// R10: software sets the status pin source select to 1 before relying on lock detect kind.
// R11: with lock detect kind 0 the status pin shows calibration done.
// R12: with lock detect kind 1, the reset value, the status pin shows tuning-voltage lock.
// R13: software writes default values into all unnamed bit ranges.
// R14: every register is 16 bits, addressed by number, read and written as a whole word.
//
// Purpose: configuration register bank for fractional divider and output buffers
// Assumes: serial port decoded upstream into word write/read strobes
// Notes:   unnamed bits are stored and read back as written
`timescale 1ns/100ps
`include "sfocr_defines.vh"
module sfocr_regs #(
  parameter NREG = 11
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        wr_en_i,
  input  wire        rd_en_i,
  input  wire [6:0]  addr_i,
  input  wire [15:0] wdata_i,
  input  wire        cal_done_i,
  input  wire        vtune_locked_i,
  output reg  [15:0] rdata_o,
  output reg         rvalid_o,
  output wire [31:0] frac_denominator_o,
  output wire [31:0] frac_numerator_o,
  output wire [31:0] modulator_seed_o,
  output wire [2:0]  modulator_order_o,
  output wire        frac_mode_o,
  output wire [5:0]  out_a_power_level_o,
  output wire        out_a_boost_o,
  output wire [5:0]  out_b_power_level_o,
  output wire        out_b_boost_o,
  output wire        out_a_powerdown_o,
  output wire        out_b_powerdown_o,
  output wire [1:0]  out_a_source_sel_o,
  output wire [1:0]  out_b_source_sel_o,
  output wire        out_a_use_osc_o,
  output wire        out_b_use_osc_o,
  output wire        mux_pin_high_drive_o,
  output wire        lock_detect_kind_o,
  output wire        mux_status_pin_o
);

  // ===================================================================
  // address table
  wire [7*NREG-1:0]  addr_tab;
  wire [16*NREG-1:0] rst_tab;
  wire [16*NREG-1:0] q_tab;
  assign addr_tab = {`SFOCR_A_LD_KIND, `SFOCR_A_MUX_DRV, `SFOCR_A_OUTB_SRC,
                     `SFOCR_A_OUTA_SRC, `SFOCR_A_PWR_MOD, `SFOCR_A_NUM_LO,
                     `SFOCR_A_NUM_HI, `SFOCR_A_SEED_LO, `SFOCR_A_SEED_HI,
                     `SFOCR_A_DEN_LO, `SFOCR_A_DEN_HI};
  localparam [16*NREG-1:0] RST_TAB = {`SFOCR_RST_LD_KIND, `SFOCR_RST_MUX_DRV,
                     `SFOCR_RST_OUTB_SRC, `SFOCR_RST_OUTA_SRC, `SFOCR_RST_PWR_MOD,
                     `SFOCR_RST_ZERO, `SFOCR_RST_ZERO, `SFOCR_RST_ZERO,
                     `SFOCR_RST_ZERO, `SFOCR_RST_DEN, `SFOCR_RST_DEN};
  assign rst_tab = RST_TAB;

  // ===================================================================
  // register storage, one word per register number
  genvar g;
  generate
    for (g = 0; g < NREG; g = g + 1) begin : g_reg
      sfocr_reg16 #(
        .RST_VAL (RST_TAB[16*g +: 16])
      ) u_reg (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .wr_i    (wr_en_i && (addr_i == addr_tab[7*g +: 7])), // [R14]
        .wdata_i (wdata_i),                                   // [R14]
        .q_o     (q_tab[16*g +: 16])
      );
    end
  endgenerate

  // ===================================================================
  // readback, unmapped numbers read zero
  reg [15:0] nxt_rdata;
  integer    i;
  always @* begin
    nxt_rdata = 16'h0000;
    for (i = 0; i < NREG; i = i + 1) begin
      if (addr_i == addr_tab[7*i +: 7]) begin
        nxt_rdata = q_tab[16*i +: 16]; // [R14]
      end
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o  <= 16'h0000;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= rd_en_i;
      if (rd_en_i) begin
        rdata_o <= nxt_rdata;
      end
    end
  end

  // ===================================================================
  // field decode
  wire [15:0] den_hi   = q_tab[16*0 +: 16];
  wire [15:0] den_lo   = q_tab[16*1 +: 16];
  wire [15:0] seed_hi  = q_tab[16*2 +: 16];
  wire [15:0] seed_lo  = q_tab[16*3 +: 16];
  wire [15:0] num_hi   = q_tab[16*4 +: 16];
  wire [15:0] num_lo   = q_tab[16*5 +: 16];
  wire [15:0] pwr_mod  = q_tab[16*6 +: 16];
  wire [15:0] outa_src = q_tab[16*7 +: 16];
  wire [15:0] outb_src = q_tab[16*8 +: 16];
  wire [15:0] mux_drv  = q_tab[16*9 +: 16];
  wire [15:0] ld_kind  = q_tab[16*10 +: 16];

  assign frac_denominator_o   = {den_hi, den_lo};                     // [R01]
  assign frac_numerator_o     = {num_hi, num_lo};                     // [R02]
  assign modulator_seed_o     = {seed_hi, seed_lo};
  assign modulator_order_o    = pwr_mod[`SFOCR_F_ORDER];              // [R03]
  assign frac_mode_o          = (modulator_order_o != `SFOCR_ORDER_INT) &&
                                (modulator_order_o <= `SFOCR_ORDER_MAX); // [R03]
  assign out_a_power_level_o  = pwr_mod[`SFOCR_F_A_POW];              // [R04]
  assign out_a_boost_o        = out_a_power_level_o >= `SFOCR_POW_BOOST_MIN; // [R04]
  assign out_b_power_level_o  = outa_src[`SFOCR_F_B_POW];             // [R05]
  assign out_b_boost_o        = out_b_power_level_o >= `SFOCR_POW_BOOST_MIN; // [R05]
  assign out_b_powerdown_o    = pwr_mod[`SFOCR_F_B_PD];               // [R06]
  assign out_a_powerdown_o    = pwr_mod[`SFOCR_F_A_PD];               // [R07]
  assign out_a_source_sel_o   = outa_src[`SFOCR_F_A_SRC];             // [R08]
  assign out_b_source_sel_o   = outb_src[`SFOCR_F_B_SRC];             // [R08]
  assign out_a_use_osc_o      = out_a_source_sel_o == `SFOCR_SRC_OSC;  // [R08]
  assign out_b_use_osc_o      = out_b_source_sel_o == `SFOCR_SRC_OSC;  // [R08]
  assign mux_pin_high_drive_o = mux_drv[`SFOCR_F_HDRV];               // [R09]
  assign lock_detect_kind_o   = ld_kind[`SFOCR_F_LD_KIND];            // [R12]

  // ===================================================================
  // status pin source
  sfocr_status_mux u_status (
    .clk_i              (clk_i),
    .rst_i              (rst_i),
    .lock_detect_kind_i (lock_detect_kind_o),
    .cal_done_i         (cal_done_i),
    .vtune_locked_i     (vtune_locked_i),
    .mux_status_pin_o   (mux_status_pin_o)
  );

endmodule

// >>> dv/sfocr_regs_asserts.sv
// Purpose: port assertions for the fractional/output register bank
// Assumes: one clock, sync active-high reset
// Notes:   bound into sfocr_regs below
`timescale 1ns/100ps
module sfocr_regs_asserts (
  input wire        clk_i,
  input wire        rst_i,
  input wire        wr_en_i,
  input wire        rd_en_i,
  input wire [6:0]  addr_i,
  input wire [15:0] wdata_i,
  input wire        cal_done_i,
  input wire        vtune_locked_i,
  input wire        rvalid_o,
  input wire [31:0] frac_denominator_o,
  input wire [31:0] frac_numerator_o,
  input wire [2:0]  modulator_order_o,
  input wire        frac_mode_o,
  input wire [5:0]  out_a_power_level_o,
  input wire        out_a_boost_o,
  input wire [1:0]  out_b_source_sel_o,
  input wire        out_b_use_osc_o,
  input wire        lock_detect_kind_o,
  input wire        mux_status_pin_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==========
  // register port
  rd_answer_a: assert property (rd_en_i |=> rvalid_o) else $error("read unanswered");
  rd_pulse_a: assert property (!rd_en_i |=> !rvalid_o) else $error("stray read answer");
  num_high_a: assert property (wr_en_i && addr_i == 7'h2c |=>
    frac_numerator_o[31:16] == $past(wdata_i)) else $error("numerator high not written");
  den_low_a: assert property (wr_en_i && addr_i == 7'h29 |=>
    frac_denominator_o[15:0] == $past(wdata_i)) else $error("denominator low not written");
  // ==========
  // decoded fields
  order_mode_a: assert property (frac_mode_o ==
    (modulator_order_o != 3'h0 && modulator_order_o <= 3'h4)) else $error("bad frac mode");
  a_boost_a: assert property (out_a_boost_o ==
    (out_a_power_level_o >= 6'h30)) else $error("bad boost A");
  b_osc_a: assert property (out_b_use_osc_o ==
    (out_b_source_sel_o == 2'h1)) else $error("bad source B");
  // ==========
  // status pin
  cal_pin_a: assert property (!$past(rst_i) && !$past(lock_detect_kind_o) |->
    mux_status_pin_o == $past(cal_done_i)) else $error("pin not cal status");
  vt_pin_a: assert property (!$past(rst_i) && $past(lock_detect_kind_o) |->
    mux_status_pin_o == $past(vtune_locked_i)) else $error("pin not vtune lock");
  cover property (wr_en_i && addr_i == 7'h2c);
  cover property (rd_en_i);
  cover property ($rose(mux_status_pin_o));
endmodule
bind sfocr_regs sfocr_regs_asserts i_chk (.clk_i, .rst_i, .wr_en_i, .rd_en_i, .addr_i,
  .wdata_i, .cal_done_i, .vtune_locked_i, .rvalid_o, .frac_denominator_o, .frac_numerator_o,
  .modulator_order_o, .frac_mode_o, .out_a_power_level_o, .out_a_boost_o,
  .out_b_source_sel_o, .out_b_use_osc_o, .lock_detect_kind_o, .mux_status_pin_o);

// >>> dv/sfocr_regs_bench.sv
// Purpose: self-checking bench for sfocr_regs
// Assumes: 100 MHz clock, sync reset held 12 cycles
// Notes:   directed scenarios only
`timescale 1ns/100ps
module sfocr_regs_bench;
  logic        clk_i = 0, rst_i = 1, wr_en_i = 0, rd_en_i = 0, cal_done_i = 0;
  logic        vtune_locked_i = 0;
  logic [6:0]  addr_i = 7'h0;
  logic [15:0] wdata_i = 16'h0;
  wire  [15:0] rdata_o;
  wire  [31:0] frac_denominator_o, frac_numerator_o, modulator_seed_o;
  wire  [5:0]  out_a_power_level_o, out_b_power_level_o;
  wire  [2:0]  modulator_order_o;
  wire  [1:0]  out_a_source_sel_o, out_b_source_sel_o;
  wire         rvalid_o, frac_mode_o, out_a_boost_o, out_b_boost_o, out_a_powerdown_o;
  wire         out_b_powerdown_o, out_a_use_osc_o, out_b_use_osc_o, mux_pin_high_drive_o;
  wire         lock_detect_kind_o, mux_status_pin_o;
  int          num_errors = 0, checked = 0, cycles = 0;
  sfocr_regs i_dut (
    .clk_i                (clk_i),
    .rst_i                (rst_i),
    .wr_en_i              (wr_en_i),
    .rd_en_i              (rd_en_i),
    .addr_i               (addr_i),
    .wdata_i              (wdata_i),
    .cal_done_i           (cal_done_i),
    .vtune_locked_i       (vtune_locked_i),
    .rdata_o              (rdata_o),
    .rvalid_o             (rvalid_o),
    .frac_denominator_o   (frac_denominator_o),
    .frac_numerator_o     (frac_numerator_o),
    .modulator_seed_o     (modulator_seed_o),
    .modulator_order_o    (modulator_order_o),
    .frac_mode_o          (frac_mode_o),
    .out_a_power_level_o  (out_a_power_level_o),
    .out_a_boost_o        (out_a_boost_o),
    .out_b_power_level_o  (out_b_power_level_o),
    .out_b_boost_o        (out_b_boost_o),
    .out_a_powerdown_o    (out_a_powerdown_o),
    .out_b_powerdown_o    (out_b_powerdown_o),
    .out_a_source_sel_o   (out_a_source_sel_o),
    .out_b_source_sel_o   (out_b_source_sel_o),
    .out_a_use_osc_o      (out_a_use_osc_o),
    .out_b_use_osc_o      (out_b_use_osc_o),
    .mux_pin_high_drive_o (mux_pin_high_drive_o),
    .lock_detect_kind_o   (lock_detect_kind_o),
    .mux_status_pin_o     (mux_status_pin_o)
  );
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      num_errors++;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    wr_en_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_en_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [6:0] a, input logic [15:0] e);
    rd_en_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_en_i <= 1'b0;
    #1 chk(rvalid_o, 1);
    chk(rdata_o, e);
    @(posedge clk_i);
  endtask
  task automatic pin(input logic e);
    repeat (2) @(posedge clk_i);
    #1 chk(mux_status_pin_o, e);
    @(posedge clk_i);
  endtask
  task automatic t_reset;
    logic [6:0]  a [11] = '{7'h28, 7'h29, 7'h2a, 7'h2b, 7'h2c, 7'h2d, 7'h2e, 7'h2f, 7'h30,
                           7'h3b, 7'h3d};
    logic [15:0] e [11] = '{16'h03e8, 16'h03e8, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0f80, 16'h0,
                           16'h0, 16'h0, 16'h0001};
    chk(out_b_powerdown_o, 1);
    chk(out_a_powerdown_o, 0);
    chk(out_a_power_level_o, 15);
    chk(mux_pin_high_drive_o, 0);
    chk(lock_detect_kind_o, 1);
    chk(out_b_source_sel_o, 0);
    wr(7'h31, 16'hffff);
    for (int i = 0; i < 11; i++) rd(a[i], e[i]);
    rd(7'h31, 16'h0);
  endtask
  task automatic t_wide;
    logic [3:0] n;
    for (int i = 0; i < 6; i++) begin
      n = i + 1;
      wr(7'h28 + i, {4{n}});
    end
    chk(frac_denominator_o, 32'h1111_2222);
    chk(modulator_seed_o, 32'h3333_4444);
    chk(frac_numerator_o, 32'h5555_6666);
    rd(7'h2c, 16'h5555);
  endtask
  task automatic t_fields;
    logic [2:0] o;
    for (int i = 0; i < 5; i++) begin
      o = i;
      wr(7'h2e, {2'h0, 6'h30, 2'h1, 3'h0, o});
      chk(modulator_order_o, o);
      chk(frac_mode_o, o != 3'h0);
      chk(out_a_boost_o, 1);
      chk({out_b_powerdown_o, out_a_powerdown_o}, 2'h1);
    end
    wr(7'h2e, 16'h0007);
    chk(modulator_order_o, 3'h7);
    chk(frac_mode_o, 0);
    chk(out_a_boost_o, 0);
    wr(7'h2f, 16'h081f);
    chk({out_a_source_sel_o, out_a_use_osc_o, out_b_boost_o}, 4'h6);
    wr(7'h2f, 16'h1030);
    chk({out_a_use_osc_o, out_b_boost_o, out_b_power_level_o}, 8'h70);
    wr(7'h30, 16'h0001);
    chk(out_b_use_osc_o, 1);
    chk(out_b_source_sel_o, 2'h1);
    wr(7'h3b, 16'h0020);
    chk(mux_pin_high_drive_o, 1);
  endtask
  // status pin source select sits outside this bank, taken as lock detect
  task automatic t_status;
    vtune_locked_i <= 1'b1;
    pin(1);
    vtune_locked_i <= 1'b0;
    pin(0);
    wr(7'h3d, 16'h0);
    chk(lock_detect_kind_o, 0);
    vtune_locked_i <= 1'b1;
    pin(0);
    cal_done_i <= 1'b1;
    pin(1);
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_wide();
    t_fields();
    t_status();
    final_report();
  end
endmodule
